// file: pkg/sbc_map.vh
`ifndef SBC_MAP_VH
`define SBC_MAP_VH

// ==========================================================
// register offsets (byte addresses)
`define SBC_REMAP_CONTROL_REG 8'h00
`define SBC_ABORT_STATUS_REG 8'h04
`define SBC_ABORT_ADDRESS_REG 8'h08

// ==========================================================
// field positions
`define SBC_REMAP_TOGGLE_BIT 0
`define SBC_UNDEF_POS 0
`define SBC_MISALIGN_POS 1
`define SBC_SIZE_LSB 8
`define SBC_TYPE_LSB 10
`define SBC_LAST_DMA_POS 16
`define SBC_LAST_CPU_POS 17
`define SBC_STICKY_DMA_POS 24
`define SBC_STICKY_CPU_POS 25

// ==========================================================
// reset values
`define SBC_REMAP_RESET 1'b0
`define SBC_STATUS_RESET 32'h0000_0000

// ==========================================================
// access size and type encodings
`define SBC_SIZE_BYTE 2'h0
`define SBC_SIZE_HALF 2'h1
`define SBC_SIZE_WORD 2'h2
`define SBC_TYPE_READ 2'h0
`define SBC_TYPE_WRITE 2'h1
`define SBC_TYPE_FETCH 2'h2

// ==========================================================
// address map
`define SBC_REGION_MEMORY 4'h0
`define SBC_REGION_PERIPH 4'hf
`define SBC_WINDOW_AREA0 8'h00
`define SBC_WINDOW_FLASH 8'h01
`define SBC_WINDOW_SRAM 8'h02
`define SBC_WINDOW_QUIET 8'h03

`endif

// file: design/sbc_arbiter.v
`timescale 1ns/1ns

module sbc_arbiter
(
  // requests
  input wire dmaReq,
  input wire cpuReq,
  // grants
  output wire dmaGrant,
  output wire cpuGrant
);

  // ==========================================================
  // fixed priority, no fairness: a busy dma can starve the cpu
  assign dmaGrant = dmaReq;
  assign cpuGrant = cpuReq & ~dmaReq;

endmodule

// file: design/sbc_decoder.v
`timescale 1ns/1ns
`include "sbc_map.vh"

module sbc_decoder
(
  // access
  input wire [31:0] addr,
  input wire remapped,
  // decode result
  output reg flashHit,
  output reg sramHit,
  output reg periphHit,
  output reg undefined
);

  // ==========================================================
  // region and 1-Mbyte window decode
  always @*
  begin
    flashHit = 1'b0;
    sramHit = 1'b0;
    periphHit = 1'b0;
    undefined = 1'b0;
    if (addr[31:28] == `SBC_REGION_PERIPH)
      periphHit = 1'b1;
    else if (addr[31:28] != `SBC_REGION_MEMORY)
      undefined = 1'b1;
    else
    begin
      case (addr[27:20])
        `SBC_WINDOW_AREA0:
        begin
          flashHit = ~remapped;
          sramHit = remapped;
        end
        `SBC_WINDOW_FLASH: flashHit = 1'b1;
        `SBC_WINDOW_SRAM: sramHit = 1'b1;
        `SBC_WINDOW_QUIET: undefined = 1'b0;
        default: undefined = 1'b1;
      endcase
    end
  end

endmodule

// file: design/sbc_system_bus_controller.v
// The implementer's own choices: the address map and the address-and-strobe port.
`timescale 1ns/1ns
`include "sbc_map.vh"

// Operation
// - dma wins over cpu, fixed priority
// - all transfers are little-endian only
// - top nibble picks region; fourteen abort
// - eight more bits pick 1-Mbyte windows
// - small memories mirror across their window
// - unassigned memory window aborts
// - window 0x003 aborts only on misalignment
// - area 0 is flash, sram after remap
// - aliased memory also at own address
// - writing a one to bit 0 toggles the remap
// - abort goes to every master together
// - capture full abort address
// - record size, type, cause, source
// - sticky per-master abort flag until read
// - misaligned word or half-word aborts
// - cpu instruction fetches skip alignment check
// - two-bit size and type encodings
// - writing zero to remap does nothing
module sbc_system_bus_controller
#(
  parameter FLASH_ADDR_BITS = 17,
  parameter SRAM_ADDR_BITS = 16
)
(
  // clock and reset
  input wire clock,
  input wire srst,
  // dma master
  input wire dmaReq,
  input wire [31:0] dmaAddr,
  input wire [1:0] dmaSize,
  input wire dmaWrite,
  input wire [31:0] dmaWdata,
  output wire dmaGrant,
  // cpu master
  input wire cpuReq,
  input wire [31:0] cpuAddr,
  input wire [1:0] cpuSize,
  input wire cpuWrite,
  input wire cpuFetch,
  input wire [31:0] cpuWdata,
  output wire cpuGrant,
  // answers shared by both masters
  output reg busAbort_q,
  output reg busRvalid_q,
  output reg [31:0] busRdata_q,
  // slave side
  output reg flashSel_q,
  output reg sramSel_q,
  output reg periphSel_q,
  output reg [31:0] slaveAddr_q,
  output reg [1:0] slaveSize_q,
  output reg slaveWrite_q,
  output reg [31:0] slaveWdata_q,
  input wire [31:0] flashRdata,
  input wire [31:0] sramRdata,
  input wire [31:0] periphRdata,
  // register port
  input wire [7:0] regAddr,
  input wire [31:0] regWdata,
  input wire regWrite,
  input wire regRead,
  output reg [31:0] regRdata_q,
  // state view
  output wire remapped
);

  // ==========================================================
  // functions

  // true when an access other than a fetch breaks the alignment of its size
  function misaligned;
    input [1:0] size;
    input [1:0] low;
    input fetch;
    begin
      misaligned = 1'b0;
      if (!fetch)
      begin
        if (size == `SBC_SIZE_WORD && low != 2'h0)
          misaligned = 1'b1;
        if (size == `SBC_SIZE_HALF && low[0])
          misaligned = 1'b1;
      end
    end
  endfunction

  // two-bit access type from the master's qualifiers
  function [1:0] accessType;
    input write;
    input fetch;
    begin
      if (fetch)
        accessType = `SBC_TYPE_FETCH;
      else if (write)
        accessType = `SBC_TYPE_WRITE;
      else
        accessType = `SBC_TYPE_READ;
    end
  endfunction

  // ==========================================================
  // arbitration

  wire anyGrant;

  sbc_arbiter arbiter
  (
    .dmaReq(dmaReq),
    .cpuReq(cpuReq),
    .dmaGrant(dmaGrant),
    .cpuGrant(cpuGrant)
  );

  assign anyGrant = dmaGrant | cpuGrant;

  // ==========================================================
  // owner mux; the dma never fetches code
  reg [31:0] selAddr;
  reg [1:0] selSize;
  reg selWrite;
  reg selFetch;
  reg [31:0] selWdata;

  always @*
  begin
    if (dmaGrant)
    begin
      selAddr = dmaAddr;
      selSize = dmaSize;
      selWrite = dmaWrite;
      selFetch = 1'b0;
      selWdata = dmaWdata;
    end
    else
    begin
      selAddr = cpuAddr;
      selSize = cpuSize;
      selWrite = cpuWrite;
      selFetch = cpuFetch;
      selWdata = cpuWdata;
    end
  end

  // ==========================================================
  // decode and abort detection
  reg remap_q;
  wire flashHit;
  wire sramHit;
  wire periphHit;
  wire undefHit;
  wire misHit;
  wire abortNow;

  sbc_decoder decoder
  (
    .addr(selAddr),
    .remapped(remap_q),
    .flashHit(flashHit),
    .sramHit(sramHit),
    .periphHit(periphHit),
    .undefined(undefHit)
  );

  assign misHit = misaligned(selSize, selAddr[1:0], selFetch);
  assign abortNow = anyGrant & (undefHit | misHit);
  assign remapped = remap_q;

  // ==========================================================
  // mirrored memory address: upper window bits are dropped
  wire [31:0] flashAddr;
  wire [31:0] sramAddr;

  assign flashAddr = {{(32 - FLASH_ADDR_BITS){1'b0}},
    selAddr[FLASH_ADDR_BITS-1:0]};
  assign sramAddr = {{(32 - SRAM_ADDR_BITS){1'b0}},
    selAddr[SRAM_ADDR_BITS-1:0]};

  // ==========================================================
  // slave side request stage; data lanes pass unswapped, since
  // byte 0 always sits on bits 7:0
  reg [31:0] slaveAddr_d;

  always @*
  begin
    if (flashHit)
      slaveAddr_d = flashAddr;
    else if (sramHit)
      slaveAddr_d = sramAddr;
    else
      slaveAddr_d = selAddr;
  end

  always @(posedge clock)
  begin
    if (srst)
    begin
      flashSel_q <= 1'b0;
      sramSel_q <= 1'b0;
      periphSel_q <= 1'b0;
      slaveAddr_q <= 32'h0000_0000;
      slaveSize_q <= 2'h0;
      slaveWrite_q <= 1'b0;
      slaveWdata_q <= 32'h0000_0000;
      busAbort_q <= 1'b0;
    end
    else
    begin
      // an aborted access is cancelled before any slave sees it
      flashSel_q <= anyGrant & flashHit & ~misHit;
      sramSel_q <= anyGrant & sramHit & ~misHit;
      periphSel_q <= anyGrant & periphHit & ~misHit;
      slaveAddr_q <= slaveAddr_d;
      slaveSize_q <= selSize;
      slaveWrite_q <= selWrite;
      slaveWdata_q <= selWdata;
      // one wire fans out to both masters; each acts on it for its own access
      busAbort_q <= abortNow;
    end
  end

  // ==========================================================
  // read return, one cycle after the slave select
  reg readPending;

  always @*
  begin
    readPending = (flashSel_q | sramSel_q | periphSel_q) & ~slaveWrite_q;
  end

  always @(posedge clock)
  begin
    if (srst)
    begin
      busRvalid_q <= 1'b0;
      busRdata_q <= 32'h0000_0000;
    end
    else
    begin
      busRvalid_q <= readPending;
      if (flashSel_q)
        busRdata_q <= flashRdata;
      else if (sramSel_q)
        busRdata_q <= sramRdata;
      else if (periphSel_q)
        busRdata_q <= periphRdata;
    end
  end

  // ==========================================================
  // remap toggle
  wire remapHit;

  assign remapHit = regWrite & (regAddr == `SBC_REMAP_CONTROL_REG);

  always @(posedge clock)
  begin
    if (srst)
      remap_q <= `SBC_REMAP_RESET;
    else if (remapHit && regWdata[`SBC_REMAP_TOGGLE_BIT])
      remap_q <= ~remap_q;
  end

  // ==========================================================
  // abort status capture
  reg [31:0] abortAddr_q;
  reg [1:0] abortSize_q;
  reg [1:0] abortType_q;
  reg abortUndef_q;
  reg abortMis_q;
  reg [1:0] lastSource_q;
  reg [1:0] sticky_q;
  wire statusRead;
  wire [1:0] sourceNow;

  assign statusRead = regRead & (regAddr == `SBC_ABORT_STATUS_REG);
  // bit 0 is the dma, bit 1 the cpu
  assign sourceNow = {cpuGrant, dmaGrant};

  always @(posedge clock)
  begin
    if (srst)
    begin
      abortAddr_q <= 32'h0000_0000;
      abortSize_q <= 2'h0;
      abortType_q <= 2'h0;
      abortUndef_q <= 1'b0;
      abortMis_q <= 1'b0;
      lastSource_q <= 2'h0;
    end
    else if (abortNow)
    begin
      abortAddr_q <= selAddr;
      abortSize_q <= selSize;
      abortType_q <= accessType(selWrite, selFetch);
      abortUndef_q <= undefHit;
      abortMis_q <= misHit;
      lastSource_q <= sourceNow;
    end
  end

  // sticky flags: a new abort in the reading cycle survives the clear
  genvar m;
  generate
    for (m = 0; m < 2; m = m + 1)
    begin : stickyFlag
      always @(posedge clock)
      begin
        if (srst)
          sticky_q[m] <= 1'b0;
        else if (abortNow && sourceNow[m])
          sticky_q[m] <= 1'b1;
        else if (statusRead)
          sticky_q[m] <= 1'b0;
      end
    end
  endgenerate

  // ==========================================================
  // register read port
  reg [31:0] statusWord;
  reg [31:0] regRdata_d;

  always @*
  begin
    statusWord = `SBC_STATUS_RESET;
    statusWord[`SBC_UNDEF_POS] = abortUndef_q;
    statusWord[`SBC_MISALIGN_POS] = abortMis_q;
    statusWord[`SBC_SIZE_LSB+1:`SBC_SIZE_LSB] = abortSize_q;
    statusWord[`SBC_TYPE_LSB+1:`SBC_TYPE_LSB] = abortType_q;
    statusWord[`SBC_LAST_DMA_POS] = lastSource_q[0];
    statusWord[`SBC_LAST_CPU_POS] = lastSource_q[1];
    statusWord[`SBC_STICKY_DMA_POS] = sticky_q[0];
    statusWord[`SBC_STICKY_CPU_POS] = sticky_q[1];
  end

  always @*
  begin
    regRdata_d = 32'h0000_0000;
    // remap control is write-only and reads as zero
    case (regAddr)
      `SBC_ABORT_STATUS_REG: regRdata_d = statusWord;
      `SBC_ABORT_ADDRESS_REG: regRdata_d = abortAddr_q;
      default: regRdata_d = 32'h0000_0000;
    endcase
  end

  always @(posedge clock)
  begin
    if (srst)
      regRdata_q <= 32'h0000_0000;
    else if (regRead)
      regRdata_q <= regRdata_d;
    else
      regRdata_q <= 32'h0000_0000;
  end

endmodule

// file: sim/sbc_checker_assertions.sv
`timescale 1ns/1ns

// ==========================================================
// bus controller checker
module sbc_checker
#(
  parameter SRAM_ADDR_BITS = 16
)
(
  // clock and reset
  input wire clock,
  input wire srst,
  // masters
  input wire dmaReq,
  input wire [31:0] dmaAddr,
  input wire [1:0] dmaSize,
  input wire dmaWrite,
  input wire [31:0] dmaWdata,
  input wire dmaGrant,
  input wire cpuReq,
  input wire [31:0] cpuAddr,
  input wire [1:0] cpuSize,
  input wire cpuWrite,
  input wire [31:0] cpuWdata,
  input wire cpuFetch,
  input wire cpuGrant,
  // answers
  input wire busAbort_q,
  input wire flashSel_q,
  input wire sramSel_q,
  input wire periphSel_q,
  input wire [31:0] slaveAddr_q,
  input wire [1:0] slaveSize_q,
  input wire slaveWrite_q,
  input wire [31:0] slaveWdata_q,
  // register port
  input wire [7:0] regAddr,
  input wire [31:0] regWdata,
  input wire regWrite,
  input wire remapped
);
  localparam [31:0] SMASK = (32'h1 << SRAM_ADDR_BITS) - 32'h1;
  wire g = dmaGrant | cpuGrant;
  wire [31:0] ga = dmaGrant ? dmaAddr : cpuAddr;
  wire [1:0] gs = dmaGrant ? dmaSize : cpuSize;
  wire gw = dmaGrant ? dmaWrite : cpuWrite;
  wire [31:0] gd = dmaGrant ? dmaWdata : cpuWdata;
  wire [11:0] w = ga[31:20];
  // only a cpu fetch escapes the alignment check
  wire gf = cpuGrant & cpuFetch;
  wire mis = !gf && ((gs == 2'h2 && ga[1:0] != 2'h0) ||
    (gs == 2'h1 && ga[0]));
  wire rw = regWrite && regAddr == 8'h00;

  default clocking @(posedge clock); endclocking
  default disable iff (srst);

  a_dma_wins:
    assert property (cpuGrant == (cpuReq && !dmaReq) && dmaGrant == dmaReq)
    else $error("grant");
  a_region_abort:
    assert property (g && w[11:8] != 4'h0 && w[11:8] != 4'hf |=> busAbort_q)
    else $error("region not aborted");
  a_window_abort:
    assert property (g && w[11:8] == 4'h0 && w[7:0] > 8'h03 |=> busAbort_q)
    else $error("window not aborted");
  a_quiet_window:
    assert property (g && w == 12'h003 && !mis |=> !busAbort_q)
    else $error("quiet window aborted");
  a_misalign_abort:
    assert property (g && mis |=> busAbort_q) else $error("misaligned");
  a_abort_cancels:
    assert property (busAbort_q |-> !(flashSel_q | sramSel_q | periphSel_q))
    else $error("select on abort");
  a_fetch_exempt:
    assert property (gf && w == 12'h001 |=> flashSel_q && !busAbort_q)
    else $error("fetch aborted");
  a_area0_map:
    assert property (g && w == 12'h000 && !mis
      |=> ($past(remapped) ? sramSel_q : flashSel_q)) else $error("area 0");
  a_sram_mirror:
    assert property (g |=> !sramSel_q || slaveAddr_q == ($past(ga) & SMASK))
    else $error("mirror");
  a_slave_lanes:
    assert property (g |=> slaveSize_q == $past(gs) &&
      slaveWrite_q == $past(gw) && slaveWdata_q == $past(gd))
    else $error("slave lanes");
  a_remap_toggle:
    assert property (rw && regWdata[0] |=> remapped != $past(remapped))
    else $error("no toggle");
  a_remap_zero:
    assert property (rw && !regWdata[0] |=> $stable(remapped))
    else $error("zero toggled");
  a_reset_flash:
    assert property (disable iff (1'b0) srst |=> !remapped)
    else $error("reset map");

  cover property (dmaReq && cpuReq);
  cover property (g && mis);
  cover property (gf && ga[1:0] != 2'h0);
  cover property (rw && regWdata[0] && remapped);
endmodule

bind sbc_system_bus_controller sbc_checker
  #(.SRAM_ADDR_BITS(SRAM_ADDR_BITS)) u_chk (.clock, .srst, .dmaReq,
  .dmaAddr, .dmaSize, .dmaWrite, .dmaWdata, .dmaGrant, .cpuReq, .cpuAddr,
  .cpuSize, .cpuWrite, .cpuWdata, .cpuFetch, .cpuGrant, .busAbort_q,
  .flashSel_q, .sramSel_q, .periphSel_q, .slaveAddr_q, .slaveSize_q,
  .slaveWrite_q, .slaveWdata_q, .regAddr, .regWdata, .regWrite, .remapped);

// file: sim/sbc_master_model.sv
`timescale 1ns/1ns

// ==========================================================
// dma and cpu masters
module sbc_master_model
(
  // clock
  input wire clock,
  // dma master
  output reg dmaReq,
  output reg [31:0] dmaAddr,
  output reg [1:0] dmaSize,
  output reg dmaWrite,
  output reg [31:0] dmaWdata,
  input wire dmaGrant,
  // cpu master
  output reg cpuReq,
  output reg [31:0] cpuAddr,
  output reg [1:0] cpuSize,
  output reg cpuWrite,
  output reg cpuFetch,
  output reg [31:0] cpuWdata,
  input wire cpuGrant,
  // shared answers
  input wire busAbort_q,
  input wire busRvalid_q,
  input wire [31:0] busRdata_q,
  output reg hung
);
  initial
  begin
    {dmaReq, dmaAddr, dmaSize, dmaWrite, dmaWdata} = 68'h0;
    {cpuReq, cpuAddr, cpuSize, cpuWrite, cpuFetch, cpuWdata} = 69'h0;
    hung = 1'b0;
  end

  // m picks the requesters: bit 1 dma, bit 0 cpu, both at once the dma goes first
  task acc(input [1:0] m, input [31:0] a, input [1:0] s, input w, f,
    output [31:0] ab, rd);
    integer i;
    reg pd, pc;
    begin
      @(posedge clock);
      pd = m[1];
      pc = m[0];
      dmaReq <= pd;
      cpuReq <= pc;
      dmaAddr <= a;
      cpuAddr <= a;
      dmaSize <= s;
      cpuSize <= s;
      dmaWrite <= w;
      cpuWrite <= w;
      cpuFetch <= f;
      // byte 0 travels in bits 7:0 on both masters
      dmaWdata <= ~a;
      cpuWdata <= a;
      ab = 32'h0;
      rd = 32'h0;
      for (i = 0; i < 8 && (pd || pc); i = i + 1)
      begin
        @(posedge clock);
        if (dmaGrant)
        begin
          dmaReq <= 1'b0;
          pd = 1'b0;
        end
        if (cpuGrant)
        begin
          cpuReq <= 1'b0;
          pc = 1'b0;
        end
      end
      if (pd || pc)
        hung = 1'b1;
      // abort only counts in the cycles after our own access
      repeat (2)
      begin
        @(posedge clock);
        if (busAbort_q)
          ab = 32'h1;
        if (busRvalid_q)
          rd = busRdata_q;
      end
    end
  endtask
endmodule

// file: sim/sbc_system_bus_controller_tb.sv
`timescale 1ns/1ns

// ==========================================================
// testbench
module sbc_system_bus_controller_tb;
  reg clock;
  reg srst;
  reg regWrite;
  reg regRead;
  reg [7:0] regAddr;
  reg [31:0] regWdata;
  wire dmaReq, cpuReq, dmaWrite, cpuWrite, cpuFetch, dmaGrant, cpuGrant;
  wire busAbort_q, busRvalid_q, remapped, hung;
  wire [1:0] dmaSize, cpuSize;
  wire [31:0] dmaAddr, dmaWdata, cpuAddr, cpuWdata;
  wire [31:0] busRdata_q, slaveAddr_q, regRdata_q;
  // slaves answer with a tag of the address they were handed
  wire [31:0] flashRdata = slaveAddr_q ^ 32'hf000_0000;
  wire [31:0] sramRdata = slaveAddr_q ^ 32'h5000_0000;
  wire [31:0] periphRdata = ~slaveAddr_q;
  integer err_total, n_checks, i;
  reg [31:0] ab, d, a;

  sbc_system_bus_controller uut (.clock, .srst, .dmaReq, .dmaAddr,
    .dmaSize, .dmaWrite, .dmaWdata, .dmaGrant, .cpuReq, .cpuAddr, .cpuSize,
    .cpuWrite, .cpuFetch, .cpuWdata, .cpuGrant, .busAbort_q, .busRvalid_q,
    .busRdata_q, .flashSel_q(), .sramSel_q(), .periphSel_q(), .slaveAddr_q,
    .slaveSize_q(), .slaveWrite_q(), .slaveWdata_q(), .flashRdata,
    .sramRdata, .periphRdata, .regAddr, .regWdata, .regWrite, .regRead,
    .regRdata_q, .remapped);

  sbc_master_model m (.clock, .dmaReq, .dmaAddr, .dmaSize, .dmaWrite,
    .dmaWdata, .dmaGrant, .cpuReq, .cpuAddr, .cpuSize, .cpuWrite, .cpuFetch,
    .cpuWdata, .cpuGrant, .busAbort_q, .busRvalid_q, .busRdata_q, .hung);

  initial
  begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  task chk(input [31:0] g, e);
    begin
      n_checks = n_checks + 1;
      if (g !== e)
      begin
        err_total = err_total + 1;
        $display("Error at %0t: got %h expected %h", $time, g, e);
      end
    end
  endtask

  task wr(input [7:0] ad, input [31:0] v);
    begin
      @(posedge clock);
      regWrite <= 1'b1;
      regAddr <= ad;
      regWdata <= v;
      @(posedge clock);
      regWrite <= 1'b0;
      #1;
    end
  endtask

  task rd(input [7:0] ad, input [31:0] e);
    begin
      @(posedge clock);
      regRead <= 1'b1;
      regAddr <= ad;
      @(posedge clock);
      regRead <= 1'b0;
      #1 chk(regRdata_q, e);
    end
  endtask

  task cx(input [1:0] mm, input [31:0] aa, input [1:0] s, input w, f, ea);
    begin
      m.acc(mm, aa, s, w, f, ab, d);
      chk(ab, {31'h0, ea});
    end
  endtask

  // f packs sticky cpu, sticky dma, last cpu, last dma, misalign, undef
  function [31:0] es(input [1:0] s, t, input [5:0] f);
    es = {6'h0, f[5:4], 6'h0, f[3:2], 4'h0, t, s, 6'h0, f[1:0]};
  endfunction

  task complete_run;
    begin
      if (hung !== 1'b0)
        err_total = err_total + 1;
      if (err_total == 0 && n_checks > 0)
        $display("Regression OK");
      else
        $display("Regression broken");
      $finish;
    end
  endtask

  initial
  begin
    err_total = 0;
    n_checks = 0;
    srst = 1'b1;
    {regWrite, regRead, regAddr, regWdata} = 42'h0;
    repeat (6) @(posedge clock);
    srst <= 1'b0;
    rd(8'h04, 32'h0);
    rd(8'h08, 32'h0);
    rd(8'h40, 32'h0);
    cx(2'b01, 32'h0021_0004, 2'h2, 1'b0, 1'b0, 1'b0);
    chk(d, 32'h5000_0004);
    cx(2'b10, 32'h0000_0008, 2'h2, 1'b0, 1'b0, 1'b0);
    chk(d, 32'hf000_0008);
    wr(8'h00, 32'hffff_fffe);
    chk({31'h0, remapped}, 32'h0);
    wr(8'h00, 32'h1);
    chk({31'h0, remapped}, 32'h1);
    cx(2'b01, 32'h0000_0008, 2'h2, 1'b0, 1'b0, 1'b0);
    chk(d, 32'h5000_0008);
    cx(2'b01, 32'h0010_0008, 2'h2, 1'b0, 1'b0, 1'b0);
    chk(d, 32'hf000_0008);
    wr(8'h00, 32'h1);
    chk({31'h0, remapped}, 32'h0);
    wr(8'h00, 32'h1);
    @(posedge clock);
    srst <= 1'b1;
    repeat (2) @(posedge clock);
    srst <= 1'b0;
    #1 chk({31'h0, remapped}, 32'h0);
    cx(2'b01, 32'h0030_0000, 2'h2, 1'b0, 1'b0, 1'b0);
    cx(2'b01, 32'h0040_0000, 2'h2, 1'b0, 1'b0, 1'b1);
    cx(2'b01, 32'hf000_0010, 2'h2, 1'b0, 1'b0, 1'b0);
    chk(d, 32'h0fff_ffef);
    for (i = 0; i < 3; i = i + 1)
    begin
      a = 32'h5000_0000 | (i << 4);
      cx(2'b01, a, i[1:0], i == 1, i == 2, 1'b1);
      rd(8'h04, es(i[1:0], i[1:0], 6'b101001));
      rd(8'h08, a);
    end
    cx(2'b01, 32'h0010_0002, 2'h2, 1'b0, 1'b1, 1'b0);
    cx(2'b01, 32'h0020_0002, 2'h2, 1'b1, 1'b0, 1'b1);
    cx(2'b10, 32'h0020_0001, 2'h1, 1'b0, 1'b0, 1'b1);
    rd(8'h04, es(2'h1, 2'h0, 6'b110110));
    rd(8'h08, 32'h0020_0001);
    cx(2'b11, 32'h6000_0000, 2'h0, 1'b0, 1'b0, 1'b1);
    rd(8'h04, es(2'h0, 2'h0, 6'b111001));
    rd(8'h04, es(2'h0, 2'h0, 6'b001001));
    complete_run;
  end
endmodule
